// [verilog/fsnf_pkg.sv]
// Constants, register map and carriers for the five-stage notch filter.
// Assumes a single control clock and a plain register port beside the sample stream.
package fsnf_pkg;
    // ****************************************
    // Stage count and field widths
    // ****************************************
    localparam int NSTAGE = 5;
    localparam int SMP_W = 16;
    localparam int ST_W = 28;
    // ****************************************
    // Setting ranges and values after reset
    // ****************************************
    localparam logic [15:0] FREQ_MIN = 16'h0032;   // 50 Hz
    localparam logic [15:0] FREQ_MAX = 16'h1388;   // 5000 Hz
    localparam logic [15:0] FREQ_RST = 16'h1388;
    localparam logic [15:0] Q_MIN = 16'h0032;      // 0.50
    localparam logic [15:0] Q_MAX = 16'h03e8;      // 10.00
    localparam logic [15:0] Q_RST = 16'h0046;      // 0.70
    localparam logic [15:0] DEPTH_MIN = 16'h0000;
    localparam logic [15:0] DEPTH_MAX = 16'h03e8;  // 1.000, no notch
    localparam logic [15:0] DEPTH_RST = 16'h0000;
    localparam logic [15:0] ENA_RST = 16'h0000;
    // Enable digit positions (nibble index) per stage
    localparam int DIG_S1 = 0;
    localparam int DIG_S2 = 2;
    localparam int DIG_S3 = 0;
    localparam int DIG_S4 = 1;
    localparam int DIG_S5 = 2;
    localparam logic [3:0] DIG_ON = 4'h1;
    // ****************************************
    // Coefficient scaling
    // ****************************************
    localparam int CTRL_RATE_HZ = 40000;            // Control sample rate
    localparam int TWO_PI_Q20 = 6588397;            // 2*pi scaled by 2^20
    localparam int F_MUL = TWO_PI_Q20 / CTRL_RATE_HZ;
    localparam int F_SHIFT = 5;                     // Q20 to Q15
    localparam int K_NUM = 100 * 16384;             // 1/Q in Q14, Q in 0.01 units
    localparam int A_MUL = 1049;                    // 2^20/1000, depth to Q10
    // ****************************************
    // Register map (word index on the register port)
    // ****************************************
    localparam logic [7:0] ADR_ENA = 8'h00;
    localparam logic [7:0] ADR_ENB = 8'h01;
    localparam logic [7:0] ADR_STAT = 8'h02;
    localparam logic [7:0] ADR_STG0 = 8'h10;         // Stage n base = ADR_STG0 + 4*n
    localparam logic [1:0] OFS_FREQ = 2'h0;
    localparam logic [1:0] OFS_Q = 2'h1;
    localparam logic [1:0] OFS_DEPTH = 2'h2;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } fsnf_req_t;
    typedef struct packed {
        logic valid;
        logic signed [SMP_W-1:0] data;
    } fsnf_smp_t;
endpackage : fsnf_pkg

// [verilog/fsnf_top.sv]
// Five cascaded notch stages in the torque reference path, with settings registers.
// Assumes synchronous inputs on i_clk, one sample per accepted valid at the control rate.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
// ****************************************
// One notch stage: state-variable core
// ****************************************
module fsnf_stage
    import fsnf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_adv,
    input wire logic i_on,
    input wire logic [15:0] i_freq,
    input wire logic [15:0] i_q,
    input wire logic [15:0] i_depth,
    input wire logic signed [SMP_W-1:0] i_x,
    output logic signed [SMP_W-1:0] o_y,
    output logic o_act
);
    logic [15:0] f_ff;
    logic [17:0] k_ff;
    logic [10:0] a_ff;
    logic signed [ST_W-1:0] low_ff, band_ff, xs, hp, band_n, low_n, bpn, att, yw;
    logic signed [47:0] p_kb, p_fh, p_fb, p_kn, p_ab;
    logic act;

    // Coefficients follow settings one cycle later; a new sample uses them at once
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            f_ff <= 16'h0000;
            k_ff <= 18'h00000;
            a_ff <= 11'h000;
        end else begin
            f_ff <= 16'((32'(i_freq) * F_MUL) >> F_SHIFT);
            k_ff <= 18'(K_NUM / 32'(i_q));
            a_ff <= 11'(((32'(DEPTH_MAX) - 32'(i_depth)) * A_MUL) >> 10);
        end
    end

    // Depth of unity or a cleared enable makes the stage a plain wire
    assign act = i_on && (i_depth < DEPTH_MAX);

    // Chamberlin core: band state before update, scaled by 1/Q and (1-depth), is removed;
    // the pre-update state keeps the notch zero on the tuned frequency instead of above it
    always_comb begin
        xs = ST_W'({{4{i_x[SMP_W-1]}}, i_x, 8'h00});
        p_kb = 48'(band_ff * $signed({1'b0, k_ff}));
        hp = xs - low_ff - p_kb[41:14];
        p_fh = 48'(hp * $signed({1'b0, f_ff}));
        band_n = band_ff + p_fh[42:15];
        p_fb = 48'(band_n * $signed({1'b0, f_ff}));
        low_n = low_ff + p_fb[42:15];
        p_kn = 48'(band_ff * $signed({1'b0, k_ff}));
        bpn = p_kn[41:14];
        p_ab = 48'(bpn * $signed({1'b0, a_ff}));
        att = p_ab[45:18];
        yw = ST_W'({{12{i_x[SMP_W-1]}}, i_x}) - att;
        if (!act) begin
            o_y = i_x;
        end else if (yw > 28'sh0007fff) begin
            o_y = 16'sh7fff;
        end else if (yw < -28'sh0008000) begin
            o_y = -16'sh8000;
        end else begin
            o_y = yw[SMP_W-1:0];
        end
    end

    // State moves only on an accepted sample; a bypassed stage restarts clean
    always_ff @(posedge i_clk) begin
        if (i_srst || !act) begin
            low_ff <= '0;
            band_ff <= '0;
        end else if (i_adv) begin
            low_ff <= low_n;
            band_ff <= band_n;
        end
    end

    assign o_act = act;
endmodule : fsnf_stage

// Operation
// - Notch stages sit in series on the torque path, each working independently.
// - Every stage has its own frequency, Q and depth setting.
// - An enabled stage attenuates components near its notch frequency.
// - Larger Q gives a narrower, steeper notch.
// - Smaller depth gives a deeper notch.
// - Depth at its maximum, unity, passes the signal unchanged.
// - First enable: digit 0 stage one, digit 2 stage two; 1 on, default off.
// - Second enable: digits 0, 1, 2 for stages three to five; default off.
// - Frequency 50 to 5000 Hz in 1 Hz steps, default 5000.
// - Q 50 to 1000 in 0.01 steps, default 70.
// - Depth 0 to 1000 in 0.001 steps, default 0.
module fsnf_top
    import fsnf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire fsnf_req_t i_req,
    output logic [15:0] o_rdata,
    input wire fsnf_smp_t i_in,
    output logic o_in_ready,
    output fsnf_smp_t o_out,
    input wire logic i_out_ready
);
    // ****************************************
    // Settings registers
    // ****************************************
    logic [15:0] ena_a_ff, ena_b_ff, rdata_ff;
    logic [15:0] freq_ff [NSTAGE];
    logic [15:0] q_ff [NSTAGE];
    logic [15:0] depth_ff [NSTAGE];
    logic [NSTAGE-1:0] on, act;
    logic signed [SMP_W-1:0] chain [NSTAGE+1];
    logic push, pop;
    fsnf_smp_t head_ff, tail_ff;
    logic rdy_ff, nxt_tail_v;

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    // Stage enables decoded from single digits of the two enable words
    assign on[0] = (ena_a_ff[DIG_S1*4 +: 4] == DIG_ON);
    assign on[1] = (ena_a_ff[DIG_S2*4 +: 4] == DIG_ON);
    assign on[2] = (ena_b_ff[DIG_S3*4 +: 4] == DIG_ON);
    assign on[3] = (ena_b_ff[DIG_S4*4 +: 4] == DIG_ON);
    assign on[4] = (ena_b_ff[DIG_S5*4 +: 4] == DIG_ON);

    // Enable words take any value; only digit value 1 turns a stage on
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ena_a_ff <= ENA_RST;
            ena_b_ff <= ENA_RST;
        end else if (i_req.wr && i_req.addr == ADR_ENA) begin
            ena_a_ff <= i_req.wdata;
        end else if (i_req.wr && i_req.addr == ADR_ENB) begin
            ena_b_ff <= i_req.wdata;
        end
    end

    // Per-stage settings; out-of-range writes are clamped so coefficients stay stable
    for (genvar n = 0; n < NSTAGE; n++) begin : g_set
        localparam logic [7:0] BASE = 8'(ADR_STG0 + 8'(4 * n));
        always_ff @(posedge i_clk) begin
            if (i_srst) begin
                freq_ff[n] <= FREQ_RST;
                q_ff[n] <= Q_RST;
                depth_ff[n] <= DEPTH_RST;
            end else if (i_req.wr && i_req.addr[7:2] == BASE[7:2]) begin
                case (i_req.addr[1:0])
                    OFS_FREQ: freq_ff[n] <= clamp(i_req.wdata, FREQ_MIN, FREQ_MAX);
                    OFS_Q: q_ff[n] <= clamp(i_req.wdata, Q_MIN, Q_MAX);
                    OFS_DEPTH: depth_ff[n] <= clamp(i_req.wdata, DEPTH_MIN, DEPTH_MAX);
                    default: ;
                endcase
            end
        end
    end

    // Read data stands the cycle after the strobe; unmapped words read zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_ff <= 16'h0000;
        end else if (i_req.rd) begin
            rdata_ff <= 16'h0000;
            if (i_req.addr == ADR_ENA) begin
                rdata_ff <= ena_a_ff;
            end else if (i_req.addr == ADR_ENB) begin
                rdata_ff <= ena_b_ff;
            end else if (i_req.addr == ADR_STAT) begin
                rdata_ff <= {6'h00, tail_ff.valid, head_ff.valid, 3'h0, act};
            end
            for (int n = 0; n < NSTAGE; n++) begin
                if (i_req.addr == 8'(ADR_STG0 + 8'(4 * n)) + 8'(OFS_FREQ)) rdata_ff <= freq_ff[n];
                if (i_req.addr == 8'(ADR_STG0 + 8'(4 * n)) + 8'(OFS_Q)) rdata_ff <= q_ff[n];
                if (i_req.addr == 8'(ADR_STG0 + 8'(4 * n)) + 8'(OFS_DEPTH)) rdata_ff <= depth_ff[n];
            end
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    // ****************************************
    // Series notch chain
    // ****************************************
    assign chain[0] = i_in.data;
    for (genvar n = 0; n < NSTAGE; n++) begin : g_stg
        // Each stage sees the previous one's output and only its own settings
        fsnf_stage u_stg (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_adv(push),
            .i_on(on[n]),
            .i_freq(freq_ff[n]),
            .i_q(q_ff[n]),
            .i_depth(depth_ff[n]),
            .i_x(chain[n]),
            .o_y(chain[n+1]),
            .o_act(act[n])
        );
    end

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    // Ready comes from a flop, so the spare entry absorbs the word that lands
    // in the cycle the receiver stalls; the chain itself never holds state for it.
    assign push = i_in.valid && rdy_ff;
    assign pop = head_ff.valid && i_out_ready;
    assign nxt_tail_v = pop ? 1'b0 : (tail_ff.valid || (push && head_ff.valid));

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            head_ff <= '0;
            tail_ff <= '0;
            rdy_ff <= 1'b0;
        end else begin
            rdy_ff <= !nxt_tail_v;
            if (pop) begin
                if (tail_ff.valid) begin
                    head_ff <= tail_ff;
                    tail_ff.valid <= 1'b0;
                end else begin
                    head_ff <= '{valid: push, data: chain[NSTAGE]};
                end
            end else if (push) begin
                if (!head_ff.valid) begin
                    head_ff <= '{valid: 1'b1, data: chain[NSTAGE]};
                end else begin
                    tail_ff <= '{valid: 1'b1, data: chain[NSTAGE]};
                end
            end
        end
    end

    assign o_rdata = rdata_ff;
    assign o_in_ready = rdy_ff;
    assign o_out = head_ff;

    // ****************************************
    // Checks
    // ****************************************
    a_freq_range: assert property (@(posedge i_clk) disable iff (i_srst) freq_ff[0] >= 16'h0032 && freq_ff[0] <= 16'h1388)
        else $error("Stage frequency out of range");
    a_q_range: assert property (@(posedge i_clk) disable iff (i_srst) q_ff[2] >= 16'h0032 && q_ff[2] <= 16'h03e8)
        else $error("Stage Q out of range");
    a_depth_range: assert property (@(posedge i_clk) disable iff (i_srst) depth_ff[4] <= 16'h03e8)
        else $error("Stage depth out of range");
    a_reset_dflt: assert property (@(posedge i_clk) $past(i_srst) |-> freq_ff[1] == 16'h1388 && q_ff[1] == 16'h0046 && depth_ff[1] == 16'h0000 && on == 5'h00)
        else $error("Settings not at defaults after reset");
    a_ena_digit: assert property (@(posedge i_clk) disable iff (i_srst) i_req.wr && i_req.addr == 8'h01 && i_req.wdata == 16'h0100 |=> on == 5'h10)
        else $error("Fifth stage enable digit misdecoded");
    a_coef_next: assert property (@(posedge i_clk) disable iff (i_srst) i_req.wr && i_req.addr == 8'h18 && i_req.wdata == 16'h03e8 |=> ##1 g_stg[2].u_stg.f_ff == 16'h1405 && !act[2] == !on[2])
        else $error("Frequency change not applied by next sample");
    a_bypass_pass: assert property (@(posedge i_clk) disable iff (i_srst) push && act == 5'h00 |=> tail_ff.valid ? tail_ff.data == $past(i_in.data) : head_ff.data == $past(i_in.data))
        else $error("Bypassed chain altered the sample");
    a_out_hold: assert property (@(posedge i_clk) disable iff (i_srst) o_out.valid && !i_out_ready |=> o_out.valid && $stable(o_out.data))
        else $error("Output word lost during stall");
    a_read_late: assert property (@(posedge i_clk) disable iff (i_srst) i_req.rd && i_req.addr == 8'h00 && !i_req.wr |=> o_rdata == $past(ena_a_ff))
        else $error("Read data wrong one cycle after strobe");
endmodule : fsnf_top

// [test/fsnf_src_model.sv]
// Speed loop side model: queues torque reference samples and offers them one at a time.
// Assumes the filter samples valid and data on i_clk and answers with a registered ready.
`timescale 1ns/1ns
module fsnf_src_model
    import fsnf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ready,
    output fsnf_smp_t o_smp
);
    // ****************************************
    // Pending samples
    // ****************************************
    logic signed [SMP_W-1:0] pend_q[$];

    task automatic push(input logic signed [SMP_W-1:0] d);
        pend_q.push_back(d);
    endtask : push

    // A sample stands until taken; an idle line carries flipped data so stale words never pass
    always @(posedge i_clk) begin
        if (o_smp.valid && i_ready) begin
            void'(pend_q.pop_front());
        end
        if (i_srst) begin
            o_smp <= '0;
        end else if (pend_q.size() > 0) begin
            o_smp <= '{1'b1, pend_q[0]};
        end else begin
            o_smp <= '{1'b0, ~o_smp.data};
        end
    end
endmodule : fsnf_src_model

// [test/testbench.sv]
// Self-checking bench for the five-stage notch filter: settings, buffer stall and tone response.
// Assumes fsnf_pkg, fsnf_top and the source model are compiled first; one 10 MHz clock.
`timescale 1ns/1ns
module testbench;
    import fsnf_pkg::*;
    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    localparam int NTONE = 480;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    fsnf_req_t req = '0;
    logic [15:0] rdata;
    fsnf_smp_t in_smp;
    fsnf_smp_t out_smp;
    logic in_rdy;
    logic out_rdy = 1'b1;
    int error_cnt = 0;
    int n_tests = 0;
    logic signed [SMP_W-1:0] out_q[$];
    logic [1:0] cl_ofs[5] = '{OFS_FREQ, OFS_FREQ, OFS_Q, OFS_Q, OFS_DEPTH};
    logic [15:0] cl_wr[5] = '{16'h0031, 16'h1389, 16'h0031, 16'h03e9, 16'h03e9};
    logic [15:0] cl_exp[5] = '{FREQ_MIN, FREQ_MAX, Q_MIN, Q_MAX, DEPTH_MAX};

    always #50 i_clk = ~i_clk;

    fsnf_top u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_req(req), .o_rdata(rdata), .i_in(in_smp),
        .o_in_ready(in_rdy), .o_out(out_smp), .i_out_ready(out_rdy));
    fsnf_src_model u_src (.i_clk(i_clk), .i_srst(i_srst), .i_ready(in_rdy), .o_smp(in_smp));

    // Collect every word the receiver takes
    always @(posedge i_clk) begin
        if (out_smp.valid === 1'b1 && out_rdy) begin
            out_q.push_back(out_smp.data);
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic test_done;
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] sa(input int s, input logic [1:0] ofs);
        return ADR_STG0 + 8'(4 * s) + {6'h00, ofs};
    endfunction : sa

    // Strobes last one cycle; an idle cycle separates calls so no signal is set twice per step
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clk);
        req <= '0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge i_clk);
        req <= '0;
        #1 chk(rdata, exp);
    endtask : rd_chk

    // Drive a sine at f_hz and return the peak of the settled last quarter
    task automatic tone(input int f_hz, input bit exact, output int peak);
        logic signed [SMP_W-1:0] x[$];
        int n;
        int v;
        peak = 0;
        n = 0;
        out_q.delete();
        for (int i = 0; i < NTONE; i++) begin
            x.push_back(SMP_W'($rtoi(8000.0 * $sin(6.2831853 * f_hz * i / real'(CTRL_RATE_HZ)))));
            u_src.push(x[i]);
        end
        while (out_q.size() < NTONE && n < 5000) begin
            @(posedge i_clk);
            n++;
        end
        chk(16'(out_q.size()), 16'(NTONE));
        for (int i = 0; i < out_q.size(); i++) begin
            if (exact) chk(out_q[i], x[i]);
            v = out_q[i];
            if (v < 0) v = -v;
            if (i >= 3 * NTONE / 4 && v > peak) peak = v;
        end
    endtask : tone

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        int pk;
        int pk2;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        // Values after reset: every stage bypassed
        rd_chk(ADR_ENA, ENA_RST);
        rd_chk(ADR_ENB, ENA_RST);
        rd_chk(ADR_STAT, 16'h0000);
        for (int s = 0; s < NSTAGE; s++) begin
            rd_chk(sa(s, OFS_FREQ), FREQ_RST);
            rd_chk(sa(s, OFS_Q), Q_RST);
            rd_chk(sa(s, OFS_DEPTH), DEPTH_RST);
        end
        rd_chk(8'h03, 16'h0000);
        // Out-of-range writes land on the nearest bound
        for (int i = 0; i < 5; i++) begin
            wr_reg(sa(4, cl_ofs[i]), cl_wr[i]);
            rd_chk(sa(4, cl_ofs[i]), cl_exp[i]);
        end
        wr_reg(sa(4, OFS_FREQ), FREQ_RST);
        wr_reg(sa(4, OFS_Q), Q_RST);
        wr_reg(sa(4, OFS_DEPTH), DEPTH_RST);
        // Only a nibble equal to one switches its stage on
        wr_reg(ADR_ENA, 16'h0101);
        rd_chk(ADR_STAT, 16'h0003);
        wr_reg(ADR_ENA, 16'h0201);
        rd_chk(ADR_STAT, 16'h0001);
        wr_reg(ADR_ENB, 16'h0121);
        rd_chk(ADR_STAT, 16'h0015);
        wr_reg(ADR_ENB, 16'h0111);
        rd_chk(ADR_STAT, 16'h001d);
        wr_reg(ADR_ENA, 16'h0000);
        wr_reg(ADR_ENB, 16'h0100);
        rd_chk(ADR_STAT, 16'h0010);
        wr_reg(ADR_ENB, 16'h0000);
        // Receiver stalls: two words buffered, the third refused until a pop
        out_rdy <= 1'b0;
        out_q.delete();
        u_src.push(16'h1234);
        u_src.push(16'hedcb);
        u_src.push(16'h7fff);
        repeat (6) @(posedge i_clk);
        #1 chk(16'(in_rdy), 16'h0000);
        rd_chk(ADR_STAT, 16'h0300);
        @(posedge i_clk);
        out_rdy <= 1'b1;
        repeat (10) @(posedge i_clk);
        chk(16'(out_q.size()), 16'h0003);
        chk(out_q[0], 16'h1234);
        chk(out_q[1], 16'hedcb);
        chk(out_q[2], 16'h7fff);
        // Settings change only while the stream is idle
        wr_reg(ADR_ENB, 16'h0001);
        wr_reg(sa(2, OFS_FREQ), 16'h03e8);
        wr_reg(sa(2, OFS_DEPTH), DEPTH_MAX);
        tone(1000, 1'b1, pk);
        wr_reg(sa(2, OFS_DEPTH), 16'h0000);
        tone(1000, 1'b0, pk);
        chk(16'(pk < 1500), 16'h0001);
        wr_reg(sa(2, OFS_DEPTH), 16'h01f4);
        tone(1000, 1'b0, pk);
        chk(16'(pk > 3000 && pk < 6000), 16'h0001);
        // Off-notch tone: wide notch eats it, narrow notch lets it through
        wr_reg(sa(2, OFS_DEPTH), 16'h0000);
        wr_reg(sa(2, OFS_Q), Q_MIN);
        tone(700, 1'b0, pk);
        wr_reg(sa(2, OFS_Q), Q_MAX);
        tone(700, 1'b0, pk2);
        chk(16'(pk < pk2 && pk2 > 7000), 16'h0001);
        // Moving stage three away frees the tone; stage one then catches it with its own setting
        wr_reg(sa(2, OFS_Q), Q_RST);
        wr_reg(sa(2, OFS_FREQ), 16'h0bb8);
        tone(1000, 1'b0, pk);
        chk(16'(pk > 6000), 16'h0001);
        wr_reg(sa(0, OFS_FREQ), 16'h03e8);
        wr_reg(ADR_ENA, 16'h0001);
        tone(1000, 1'b0, pk);
        chk(16'(pk < 1500), 16'h0001);
        test_done();
    end

    // Roughly ten times the expected run length
    initial begin
        repeat (40000) @(posedge i_clk);
        error_cnt++;
        test_done();
    end
endmodule : testbench
